// ===== rst_seq_pkg.sv
/*
  Constants, types and the register map of the reset source sequencer.
  Assumes a single 100 MHz core clock and a plain strobe register port.
*/
// Operation
// - Eight causes: power-on, pin, pin asleep, watchdog, brown-out, instruction, trap, illegal.
// - Watchdog wake-up resumes operation; no system reset, registers keep contents.
// - Master-clear pin is filtered; short pulses are ignored.
// - Master-clear pin is input only; internal resets never drive it.
// - Power-on pulse clears the power-on timer and enters reset.
// - On power-on the clock source comes from the oscillator configuration word.
// - After power-on wait the 10 us bias settle delay first.
// - Then apply power-up timeout: none, 4 ms, 16 ms or 64 ms.
// - After both delays release system reset on next first clock phase edge.
// - Monitor on and clock not ready at expiry: raise clock failure, use fast RC.
// - Monitor and timer off: leave reset fast; RC and external clocks run at once; the code still adds the 100 us delay for a crystal.
// - Monitor off and no clock: hold at reset vector until the clock starts.
// - Brown-out detection resets the device; trip level has three settings; the 2-bit brownout_level offers four.
// - On brown-out reselect clock from group select and primary mode fields.
// - Brown-out with oscillator mode starts start-up timer; clock held until expiry.
// - Brown-out with PLL holds clock until the PLL lock bit reads one.
// - Brown-out sets the brown-out flag in bit 1 of reset status.
// - Zero timeout with crystal adds a 100 us monitor start-up delay.
package rst_seq_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BIAS_SETTLE_US = 10;
  localparam int unsigned MONITOR_START_US = 100;
  localparam int unsigned POWERUP_TIMER_4_MS = 4;
  localparam int unsigned POWERUP_TIMER_16_MS = 16;
  localparam int unsigned POWERUP_TIMER_64_MS = 64;
  localparam int unsigned BIAS_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam int unsigned MONITOR_CYC = MONITOR_START_US * CLK_MHZ;
  localparam int unsigned POWERUP_TIMER_4_CYC = POWERUP_TIMER_4_MS * 1000 * CLK_MHZ;
  localparam int unsigned POWERUP_TIMER_16_CYC = POWERUP_TIMER_16_MS * 1000 * CLK_MHZ;
  localparam int unsigned POWERUP_TIMER_64_CYC = POWERUP_TIMER_64_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned FILT_DEFAULT = 8;

  // Register indices on the strobe port (word addresses).
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_OSC_CFG = 4'h3;
  localparam logic [3:0] ADDR_CLOCK = 4'h4;

  // Reset status bit positions; brown-out is fixed at bit 1.
  localparam int unsigned ST_POR = 0;
  localparam int unsigned ST_BOR = 1;
  localparam int unsigned ST_SLEEP = 3;
  localparam int unsigned ST_WDTO = 4;
  localparam int unsigned ST_SWR = 6;
  localparam int unsigned ST_EXTR = 7;
  localparam int unsigned ST_IOPU = 14;
  localparam int unsigned ST_TRAP = 15;
  localparam int unsigned ST_CF = 8;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // Oscillator configuration word fields.
  localparam int unsigned FPR_LO = 0;
  localparam int unsigned FOS_LO = 8;
  localparam int unsigned FCK_LO = 14;
  localparam logic [2:0] FOS_LPOSC = 3'h0;
  localparam logic [2:0] FOS_FRC = 3'h1;
  localparam logic [2:0] FOS_INTERNAL_LOW_POWER_RC = 3'h2;
  localparam logic [2:0] FOS_EXT = 3'h3;
  localparam logic [4:0] FPR_EC = 5'h0B;
  localparam logic [4:0] FPR_ERC = 5'h08;
  localparam logic [4:0] FPR_PLL_MIN = 5'h04;
  localparam logic [4:0] FPR_PLL_MAX = 5'h07;
  localparam logic [23:0] OSC_CFG_RESET = 24'h00C301;

  typedef enum logic [1:0] {
    POWERUP_TIMER_NONE = 2'b00,
    POWERUP_TIMER_4 = 2'b01,
    POWERUP_TIMER_16 = 2'b10,
    POWERUP_TIMER_64 = 2'b11
  } powerup_timer_sel_e;

  typedef enum logic [2:0] {
    SQ_HOLD = 3'b000,
    SQ_BIAS = 3'b001,
    SQ_POWERUP_TIMER = 3'b010,
    SQ_PHASE = 3'b011,
    SQ_CLKWAIT = 3'b100,
    SQ_RUN = 3'b101
  } seq_state_e;

  typedef enum logic [1:0] {
    SRC_FRC = 2'b00,
    SRC_INTERNAL_LOW_POWER_RC = 2'b01,
    SRC_PRIMARY = 2'b10,
    SRC_SECONDARY = 2'b11
  } clk_src_e;

  typedef struct packed {
    logic power_on;
    logic brownout_reset;
    logic watchdog_timer;
    logic wdt_in_sleep;
    logic reset_instr;
    logic trap_lockup_reset;
    logic illegal_op_reset;
    logic in_sleep;
  } reset_events_s;

  typedef struct packed {
    logic osc_running;
    logic ost_expired;
    logic pll_locked;
    logic first_clock_phase;
  } clock_status_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// ===== pin_filter.sv
/*
  Noise filter and synchroniser for the master-clear pin.
  Assumes an asynchronous pin; output is a clean level on core_clk.
*/
`timescale 1ns/1ns
module pin_filter #(
  parameter int unsigned FILT = 8
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic pin_n, // Raw pin level, active low.
  output logic asserted // Filtered assertion level.
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [7:0] cnt;
    logic level;
  } filt_state_s;

  filt_state_s st;
  filt_state_s next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = ~pin_n;
    next_st.sync2 = st.sync1;
    // A level must persist FILT cycles; shorter pulses restart the count.
    if (st.sync2 == st.level) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt == 8'(FILT - 1)) begin
      next_st.level = st.sync2;
      next_st.cnt = 8'h00;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign asserted = st.level;

  glitch_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st.sync2) ##1 $fell(st.sync2) |-> !st.level)
    else $error("short pin pulse passed the filter");
endmodule

// ===== reset_source_sequencer.sv
/*
  Reset source sequencer: collects reset causes, times bias and power-up
  delays, releases the system reset on a clock phase edge and picks the clock.
  Assumes supply monitors and core events are synchronous to core_clk, and
  that the pin-side master clear arrives asynchronously.
*/
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
module reset_source_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned BIAS_CYCLES = BIAS_CYC,
  parameter int unsigned MONITOR_CYCLES = MONITOR_CYC,
  parameter int unsigned PWRT4_CYCLES = POWERUP_TIMER_4_CYC,
  parameter int unsigned PWRT16_CYCLES = POWERUP_TIMER_16_CYC,
  parameter int unsigned PWRT64_CYCLES = POWERUP_TIMER_64_CYC,
  parameter int unsigned FILT_CYCLES = FILT_DEFAULT
) (
  input wire logic core_clk, // Core clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic master_clear_pin_n, // External master clear pin, active low.
  input wire rst_seq_pkg::reset_events_s events, // Single-cycle reset cause pulses.
  input wire rst_seq_pkg::clock_status_s clk_status, // Oscillator state.
  input wire logic [3:0] addr, // Register word address.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [15:0] rdata, // Read data, valid the cycle after rd.
  output logic system_reset_n, // Internal system reset, active low.
  output logic wake_resume, // Pulse: watchdog wake-up resumes execution.
  output logic clock_fail_trap, // Pulse: clock failure trap.
  output rst_seq_pkg::clk_src_e clk_source, // Selected clock source.
  output logic clock_enable, // System clock released to the core.
  output logic [1:0] brownout_level, // Brown-out trip level select.
  output logic irq // Interrupt, high while an unmasked status bit is set.
);
  import rst_seq_pkg::*;

  typedef struct packed {
    seq_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [15:0] status;
    logic [15:0] mask;
    logic [23:0] osc_cfg;
    powerup_timer_sel_e powerup_timer;
    logic [1:0] bor_level;
    logic clk_hold;
    logic [15:0] rdata;
    clk_src_e src;
    logic trap;
    logic wake;
  } seq_state_s;

  seq_state_s st;
  seq_state_s next_st;
  logic master_clear_pin;
  logic master_clear_pin_q;
  logic sys_event;

  pin_filter #(.FILT(FILT_CYCLES)) u_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_n(master_clear_pin_n),
    .asserted(master_clear_pin)
  );

  function automatic logic [CNT_W-1:0] powerup_timer_cycles(input powerup_timer_sel_e sel);
    unique case (sel)
      POWERUP_TIMER_NONE: powerup_timer_cycles = '0;
      POWERUP_TIMER_4: powerup_timer_cycles = CNT_W'(PWRT4_CYCLES);
      POWERUP_TIMER_16: powerup_timer_cycles = CNT_W'(PWRT16_CYCLES);
      POWERUP_TIMER_64: powerup_timer_cycles = CNT_W'(PWRT64_CYCLES);
    endcase
  endfunction

  function automatic clk_src_e pick_source(input logic [23:0] cfg);
    unique case (cfg[FOS_LO +: 3])
      FOS_FRC: pick_source = SRC_FRC;
      FOS_INTERNAL_LOW_POWER_RC: pick_source = SRC_INTERNAL_LOW_POWER_RC;
      FOS_LPOSC: pick_source = SRC_SECONDARY;
      default: pick_source = SRC_PRIMARY;
    endcase
  endfunction

  function automatic logic is_crystal(input logic [23:0] cfg);
    logic [4:0] fpr;
    fpr = cfg[FPR_LO +: 5];
    is_crystal = (cfg[FOS_LO +: 3] == FOS_LPOSC) ||
                 ((cfg[FOS_LO +: 3] == FOS_EXT) && fpr != FPR_EC && fpr != FPR_ERC);
  endfunction

  function automatic logic uses_pll(input logic [23:0] cfg);
    uses_pll = (cfg[FOS_LO +: 3] == FOS_EXT) &&
               (cfg[FPR_LO +: 5] >= FPR_PLL_MIN) && (cfg[FPR_LO +: 5] <= FPR_PLL_MAX);
  endfunction

  logic monitor_on;
  logic clk_ready;
  assign monitor_on = (st.osc_cfg[FCK_LO +: 2] == 2'b00);
  assign clk_ready = clk_status.osc_running &&
                     (!is_crystal(st.osc_cfg) || clk_status.ost_expired) &&
                     (!uses_pll(st.osc_cfg) || clk_status.pll_locked);
  assign sys_event = events.power_on || events.brownout_reset || events.watchdog_timer ||
                     events.reset_instr || events.trap_lockup_reset ||
                     events.illegal_op_reset || (master_clear_pin && !master_clear_pin_q);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_q <= 1'b0;
    end else begin
      master_clear_pin_q <= master_clear_pin;
    end
  end

  always_comb begin
    next_st = st;
    next_st.trap = 1'b0;
    next_st.wake = 1'b0;
    next_st.rdata = 16'h0000;
    // Software clear comes first so that a same-cycle event still sets its bit.
    if (wr && addr == ADDR_STATUS) begin
      next_st.status = st.status & ~wdata;
    end
    if (wr && addr == ADDR_MASK) begin
      next_st.mask = wdata;
    end
    if (wr && addr == ADDR_CONFIG) begin
      next_st.powerup_timer = powerup_timer_sel_e'(wdata[1:0]);
      next_st.bor_level = wdata[3:2];
    end
    if (wr && addr == ADDR_OSC_CFG) begin
      next_st.osc_cfg = {st.osc_cfg[23:16], wdata};
    end
    if (rd) begin
      unique case (addr)
        ADDR_STATUS: next_st.rdata = st.status;
        ADDR_MASK: next_st.rdata = st.mask;
        ADDR_CONFIG: next_st.rdata = {12'h000, st.bor_level, st.powerup_timer};
        ADDR_OSC_CFG: next_st.rdata = st.osc_cfg[15:0];
        ADDR_CLOCK: next_st.rdata = {9'h000, st.state, st.clk_hold, st.src, clock_enable};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Cause flags are sticky and set by hardware events.
    if (events.power_on) begin
      next_st.status[ST_POR] = 1'b1;
      next_st.status[ST_BOR] = 1'b1;
    end
    if (events.brownout_reset) begin
      next_st.status[ST_BOR] = 1'b1;
    end
    if (events.watchdog_timer || events.wdt_in_sleep) begin
      next_st.status[ST_WDTO] = 1'b1;
    end
    if (events.wdt_in_sleep) begin
      next_st.status[ST_SLEEP] = 1'b1;
    end
    if (events.reset_instr) begin
      next_st.status[ST_SWR] = 1'b1;
    end
    if (events.trap_lockup_reset) begin
      next_st.status[ST_TRAP] = 1'b1;
    end
    if (events.illegal_op_reset) begin
      next_st.status[ST_IOPU] = 1'b1;
    end
    if (master_clear_pin && !master_clear_pin_q) begin
      next_st.status[ST_EXTR] = 1'b1;
      if (events.in_sleep) begin
        next_st.status[ST_SLEEP] = 1'b1;
      end
    end
    // A watchdog wake from sleep only resumes; the sequencer is not restarted.
    if (events.wdt_in_sleep && !sys_event) begin
      next_st.wake = 1'b1;
    end
    if (sys_event) begin
      next_st.state = SQ_HOLD;
      next_st.cnt = '0;
      if (events.power_on || events.brownout_reset) begin
        next_st.src = pick_source(st.osc_cfg);
        next_st.clk_hold = is_crystal(st.osc_cfg) || uses_pll(st.osc_cfg);
      end
    end else begin
      unique case (st.state)
        SQ_HOLD: begin
          if (!master_clear_pin) begin
            next_st.state = SQ_BIAS;
          end
        end
        SQ_BIAS: begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt >= CNT_W'(BIAS_CYCLES - 1)) begin
            next_st.cnt = '0;
            next_st.state = SQ_POWERUP_TIMER;
          end
        end
        SQ_POWERUP_TIMER: begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.powerup_timer == POWERUP_TIMER_NONE && is_crystal(st.osc_cfg)) begin
            if (st.cnt >= CNT_W'(MONITOR_CYCLES - 1)) begin
              next_st.state = SQ_PHASE;
            end
          end else if (st.powerup_timer == POWERUP_TIMER_NONE ||
                       st.cnt >= powerup_timer_cycles(st.powerup_timer) - 1'b1) begin
            next_st.state = SQ_PHASE;
          end
        end
        SQ_PHASE: begin
          next_st.cnt = '0;
          // The trap path also leaves reset on the phase edge, like a normal release.
          if (clk_status.first_clock_phase) begin
            if (monitor_on && !clk_ready) begin
              next_st.trap = 1'b1;
              next_st.src = SRC_FRC;
              next_st.clk_hold = 1'b0;
              next_st.status[ST_CF] = 1'b1;
              next_st.state = SQ_RUN;
            end else begin
              next_st.state = SQ_CLKWAIT;
            end
          end
        end
        SQ_CLKWAIT: begin
          if (clk_ready) begin
            next_st.clk_hold = 1'b0;
            next_st.state = SQ_RUN;
          end
        end
        SQ_RUN: next_st.state = SQ_RUN;
        default: next_st.state = SQ_HOLD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: SQ_HOLD, cnt: '0, status: STATUS_RESET, mask: MASK_RESET,
              osc_cfg: OSC_CFG_RESET, powerup_timer: POWERUP_TIMER_NONE, bor_level: 2'b00,
              clk_hold: 1'b1, rdata: 16'h0000, src: SRC_FRC, trap: 1'b0, wake: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Reset leaves only after the phase edge; frozen at the vector until clock runs.
  assign system_reset_n = (st.state == SQ_CLKWAIT) || (st.state == SQ_RUN);
  assign clock_enable = (st.state == SQ_RUN) && !st.clk_hold;
  assign rdata = st.rdata;
  assign wake_resume = st.wake;
  assign clock_fail_trap = st.trap;
  assign clk_source = st.src;
  assign brownout_level = st.bor_level;
  assign irq = |(st.status & st.mask);

  por_restarts_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.power_on |=> st.state == SQ_HOLD && !system_reset_n)
    else $error("power-on did not enter reset");
  bor_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.brownout_reset |=> st.status[ST_BOR])
    else $error("brown-out flag not set");
  bias_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st.state == SQ_BIAS) && !sys_event |=> st.state == SQ_BIAS [*8])
    else $error("bias delay cut short");
  release_phase_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(system_reset_n) |-> $past(clk_status.first_clock_phase))
    else $error("reset released off phase edge");
  fail_trap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.state == SQ_PHASE && monitor_on && !clk_ready && !sys_event &&
    clk_status.first_clock_phase
    |=> clock_fail_trap && clk_source == SRC_FRC)
    else $error("clock failure not trapped");
  frozen_clock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.state == SQ_CLKWAIT && !clk_ready |-> !clock_enable)
    else $error("clock released before ready");
  wake_no_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.wdt_in_sleep && !sys_event && system_reset_n |=> system_reset_n && wake_resume)
    else $error("watchdog wake caused reset");
  cause_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.trap_lockup_reset |=> st.status[ST_TRAP] ##1 st.status[ST_TRAP] || $past(wr))
    else $error("trap cause flag not kept");
  powerup_timer_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.state == SQ_POWERUP_TIMER && st.powerup_timer != POWERUP_TIMER_NONE && st.cnt == '0 && !sys_event
    |=> st.state == SQ_POWERUP_TIMER)
    else $error("power-up timeout skipped");

  release_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(system_reset_n));
  trap_c: cover property (@(posedge core_clk) disable iff (!rst_n) clock_fail_trap);
  wake_c: cover property (@(posedge core_clk) disable iff (!rst_n) wake_resume);
  bor_c: cover property (@(posedge core_clk) disable iff (!rst_n) events.brownout_reset);
endmodule

// ===== supply_pin_model.sv
/*
  Model of the far side: master-clear pin with pull-up, and the oscillator
  status (running, start-up timer, PLL lock, first clock phase pulses).
  Assumes the testbench requests pin pulls and oscillator states by level.
*/
`timescale 1ns/1ns
module supply_pin_model
  import rst_seq_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Model reset, active low.
  input wire logic pin_low, // Request to pull the pin low.
  input wire logic osc_ok, // Oscillator is oscillating.
  input wire logic pll_ok, // PLL has locked.
  output logic master_clear_pin_n, // Master-clear pin level.
  output rst_seq_pkg::clock_status_s clk_status // Oscillator state seen by the core.
);
  logic [1:0] phase_cnt;
  logic [3:0] ost_cnt;

  // The pin has a pull-up; only this side ever pulls it low.
  assign master_clear_pin_n = pin_low ? 1'b0 : 1'b1;
  // The start-up timer restarts whenever the oscillator stops, so a late crystal is held back.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt <= 2'h0;
      ost_cnt <= 4'h0;
    end else begin
      phase_cnt <= phase_cnt + 2'h1;
      ost_cnt <= !osc_ok ? 4'h0 : (ost_cnt == 4'h8 ? ost_cnt : ost_cnt + 4'h1);
    end
  end
  assign clk_status = {osc_ok, ost_cnt == 4'h8, pll_ok, phase_cnt == 2'h3};
endmodule

// ===== test_reset_source_sequencer.sv
/*
  Self-checking testbench of the reset source sequencer with short counts.
  Assumes the supply and pin model beside it and the package constants.
*/
`timescale 1ns/1ns
module test_reset_source_sequencer;
  import rst_seq_pkg::*;
  localparam int BIAS = 10;
  localparam int MON = 4;
  localparam int PW[4] = '{1, 16, 32, 64};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_low = 1'b0;
  logic osc_ok = 1'b1;
  logic pll_ok = 1'b1;
  reset_events_s events = '0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic system_reset_n, wake_resume, clock_fail_trap, clock_enable, irq, master_clear_pin_n;
  clk_src_e clk_source;
  logic [1:0] brownout_level;
  clock_status_s clk_status;
  int fails = 0;
  int check_count = 0;
  int cycles;
  int low;
  int wake;
  logic trap_seen;
  logic [15:0] word;

  always #5 core_clk = ~core_clk;

  supply_pin_model u_supply_pin_model (.core_clk(core_clk), .rst_n(rst_n), .pin_low(pin_low),
    .osc_ok(osc_ok), .pll_ok(pll_ok), .master_clear_pin_n(master_clear_pin_n),
    .clk_status(clk_status));

  reset_source_sequencer #(.BIAS_CYCLES(BIAS), .MONITOR_CYCLES(MON), .PWRT4_CYCLES(16),
    .PWRT16_CYCLES(32), .PWRT64_CYCLES(64), .FILT_CYCLES(4)) u_reset_source_sequencer (
    .core_clk(core_clk), .rst_n(rst_n), .master_clear_pin_n(master_clear_pin_n),
    .events(events), .clk_status(clk_status), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .system_reset_n(system_reset_n), .wake_resume(wake_resume),
    .clock_fail_trap(clock_fail_trap), .clk_source(clk_source), .clock_enable(clock_enable),
    .brownout_level(brownout_level), .irq(irq));

  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_range(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Event bits and the sleep level are held for pins cycles, or for one cycle when pins is zero; the pin is pulled low only when pins is nonzero.
  task automatic pulse(input logic [7:0] v, input int pins);
    @(posedge core_clk);
    events <= reset_events_s'(v);
    pin_low <= (pins > 0);
    repeat (pins > 0 ? pins : 1) @(posedge core_clk);
    events <= '0;
    pin_low <= 1'b0;
  endtask

  task automatic hold_count(input int limit, output int n);
    n = 0;
    while (clock_enable !== 1'b1 && n < limit) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task automatic watch(input int n);
    low = 0;
    wake = 0;
    #1;
    repeat (n) begin
      low += (system_reset_n !== 1'b1);
      wake += (wake_resume === 1'b1);
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic wait_release(input string what, input int lo, input int span);
    logic prev_phase;
    prev_phase = 1'b0;
    cycles = 0;
    trap_seen = 1'b0;
    #1;
    while (system_reset_n !== 1'b1 && cycles < 2000) begin
      prev_phase = clk_status.first_clock_phase;
      @(posedge core_clk);
      #1;
      cycles++;
      trap_seen |= clock_fail_trap;
    end
    cmp_range(what, lo, lo + span, cycles);
    cmp_word("release on phase edge", 16'h0001, 16'(prev_phase));
    repeat (3) begin
      @(posedge core_clk);
      #1;
      trap_seen |= clock_fail_trap;
    end
  endtask

  task automatic reset_case(input string what, input logic [7:0] v, input int pins, input int lo,
    input logic [15:0] st);
    reg_write(ADDR_STATUS, 16'hFFFF);
    pulse(v, pins);
    wait_release(what, lo, pins > 0 ? 16 : 8);
    reg_read(ADDR_STATUS, word);
    cmp_word(what, st, word);
  endtask

  task automatic t_reset_values;
    #1;
    cmp_word("system reset at start", 16'h0000, 16'(system_reset_n));
    cmp_word("source at start", 16'(SRC_FRC), 16'(clk_source));
    reg_read(ADDR_STATUS, word);
    cmp_word("status reset", STATUS_RESET, word);
    reg_read(ADDR_MASK, word);
    cmp_word("mask reset", MASK_RESET, word);
    reg_read(ADDR_OSC_CFG, word);
    cmp_word("osc cfg reset", OSC_CFG_RESET[15:0], word);
    reg_read(4'hF, word);
    cmp_word("unmapped read", 16'h0000, word);
    wait_release("boot", 0, 500);
  endtask

  task automatic t_timeout_select;
    for (int i = 0; i < 4; i++) begin
      reg_write(ADDR_CONFIG, 16'(i * 5));
      #1;
      cmp_word("brownout level", 16'(i), 16'(brownout_level));
      reset_case("timeout", 8'h08, 0, BIAS + PW[i], 16'h0040);
    end
    reg_write(ADDR_CONFIG, 16'h0000);
  endtask

  task automatic t_causes;
    logic [7:0] ev[5] = '{8'h20, 8'h04, 8'h02, 8'h00, 8'h01};
    logic [15:0] st[5] = '{16'h0010, 16'h8000, 16'h4000, 16'h0080, 16'h0088};
    for (int i = 0; i < 5; i++) begin
      reset_case("cause", ev[i], i > 2 ? 10 : 0, BIAS + 1, st[i]);
    end
    pulse(8'h00, 2);
    watch(14);
    cmp_range("short pin pulse", 0, 0, low);
    reg_write(ADDR_STATUS, 16'hFFFF);
    pulse(8'h11, 0);
    watch(6);
    cmp_range("wake keeps running", 0, 0, low);
    cmp_range("wake pulse", 1, 1, wake);
    reg_read(ADDR_STATUS, word);
    cmp_word("wake status", 16'h0018, word);
  endtask

  // A slow crystal after brown-out: release still times out, the clock waits for the oscillator.
  task automatic t_oscillators;
    reset_case("power-on", 8'h80, 0, BIAS + 1, 16'h0003);
    cmp_word("power-on source", 16'(SRC_PRIMARY), 16'(clk_source));
    reg_write(ADDR_OSC_CFG, 16'hC000);
    osc_ok <= 1'b0;
    reset_case("crystal", 8'h40, 0, BIAS + MON, 16'h0002);
    cmp_word("crystal source", 16'(SRC_SECONDARY), 16'(clk_source));
    hold_count(20, cycles);
    cmp_range("clock held", 20, 20, cycles);
    @(posedge core_clk);
    osc_ok <= 1'b1;
    hold_count(40, cycles);
    cmp_range("start-up wait", 8, 16, cycles);
    reg_write(ADDR_OSC_CFG, 16'hC304);
    pll_ok <= 1'b0;
    reset_case("pll", 8'h40, 0, BIAS + MON, 16'h0002);
    cmp_word("pll source", 16'(SRC_PRIMARY), 16'(clk_source));
    hold_count(20, cycles);
    cmp_range("pll held", 20, 20, cycles);
    @(posedge core_clk);
    pll_ok <= 1'b1;
    hold_count(40, cycles);
    cmp_range("lock wait", 1, 4, cycles);
  endtask

  task automatic t_monitor_irq;
    reg_write(ADDR_OSC_CFG, 16'h0301);
    osc_ok <= 1'b0;
    reset_case("monitor", 8'h08, 0, BIAS + MON, 16'h0140);
    cmp_word("trap seen", 16'h0001, 16'(trap_seen));
    cmp_word("trap source", 16'(SRC_FRC), 16'(clk_source));
    reg_write(ADDR_MASK, 16'h0100);
    reg_write(ADDR_MASK, 16'h0100);
    cmp_word("irq unmasked", 16'h0001, 16'(irq));
    reg_write(ADDR_MASK, 16'h0000);
    reg_write(ADDR_MASK, 16'h0000);
    cmp_word("irq masked", 16'h0000, 16'(irq));
    reg_write(ADDR_MASK, 16'h0100);
    reg_write(ADDR_STATUS, 16'h0100);
    reg_write(ADDR_MASK, 16'h0100);
    cmp_word("irq cleared", 16'h0000, 16'(irq));
    osc_ok <= 1'b1;
    reg_write(ADDR_OSC_CFG, 16'hC301);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fails++;
    complete_run;
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_values;
    t_oscillators;
    t_timeout_select;
    t_causes;
    t_monitor_irq;
    complete_run;
  end
endmodule
